// *** tpw_pkg.sv ***
// Purpose: Shared constants for the timer based PWM output block
// Assumes: 8-bit registers on a 32-bit classic Wishbone bus, one word each
// Notes:   Offsets are byte addresses; data sits in the low byte
//
// Summary of operation
// - Pin carries PWM with 10-bit duty resolution
// - Zero control write forces PWM latch low
// - Period is (period_register+1)*4*Tosc*prescale
// - Timer restarts after matching period_register
// - Period end sets pin unless duty zero
// - Period end copies duty into duty_shadow
// - Postscaler never changes PWM period
// - Duty is duty_high_write with control bits 5:4
// - High time is duty*Tosc*prescale
// - Duty writes take effect next period
// - duty_shadow read-only in PWM mode
// - Shadow plus 2-bit latch double-buffer duty
// - Pin clears when extended timer matches duty
// - Duty beyond period keeps pin high

package tpw_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] TPW_OFS_CONTROL    = 8'h00;
   localparam logic [7:0] TPW_OFS_PERIOD     = 8'h04;
   localparam logic [7:0] TPW_OFS_DUTY_HIGH  = 8'h08;
   localparam logic [7:0] TPW_OFS_DUTY_SHDW  = 8'h0c;
   localparam logic [7:0] TPW_OFS_TIMER      = 8'h10;
   localparam logic [7:0] TPW_OFS_TIMER_CTRL = 8'h14;
   localparam logic [7:0] TPW_OFS_STATUS     = 8'h18;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int TPW_CTL_MODE_LSB  = 0;
   localparam int TPW_CTL_DUTY_LSB  = 4;
   localparam int TPW_TCN_PRE_LSB   = 0;
   localparam int TPW_TCN_ON_BIT    = 2;
   localparam int TPW_TCN_POST_LSB  = 3;
   localparam int TPW_STS_PIN_BIT   = 0;
   localparam int TPW_STS_POST_BIT  = 1;

   // ------------------------------------------------------------
   // Encodings and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] TPW_MODE_PWM     = 4'hc;
   localparam logic [7:0] TPW_RST_CONTROL  = 8'h00;
   localparam logic [7:0] TPW_RST_PERIOD   = 8'hff;
   localparam logic [7:0] TPW_RST_DUTY     = 8'h00;
   localparam logic [7:0] TPW_RST_TCTRL    = 8'h00;
   localparam int         TPW_Q_PER_CYCLE  = 4;

endpackage : tpw_pkg

// *** tpw_prescaler.sv ***
// Purpose: Instruction-cycle divider and timer prescaler
// Assumes: Oscillator period equals one ref_clk_in period
// Notes:   fine_out is the two extra compare bits below the timer

`timescale 1ns/1ps

module tpw_prescaler
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Control
   input  wire logic       run_in,
   input  wire logic [1:0] pre_sel_in,
   // Timing
   output logic            tick_out,
   output logic            step_end_out,
   output logic [1:0]      fine_out
);

   logic [5:0] cnt_reg;
   logic [5:0] last;

   // Prescale 1, 4 or 16 times four oscillator periods
   always_comb
   begin
      if (pre_sel_in == 2'h0)
         last = 6'h03;
      else if (pre_sel_in == 2'h1)
         last = 6'h0f;
      else
         last = 6'h3f;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         cnt_reg <= 6'h00;
      else if (!run_in || cnt_reg == last)
         cnt_reg <= 6'h00;
      else
         cnt_reg <= cnt_reg + 6'h01;
   end

   // Fine bits step once per prescaled oscillator period
   always_comb
   begin
      tick_out = run_in && (cnt_reg == last);
      if (pre_sel_in == 2'h0)
      begin
         fine_out     = cnt_reg[1:0];
         step_end_out = run_in;
      end
      else if (pre_sel_in == 2'h1)
      begin
         fine_out     = cnt_reg[3:2];
         step_end_out = run_in && (cnt_reg[1:0] == 2'h3);
      end
      else
      begin
         fine_out     = cnt_reg[5:4];
         step_end_out = run_in && (cnt_reg[3:0] == 4'hf);
      end
   end

endmodule // tpw_prescaler

// *** tpw_postscaler.sv ***
// Purpose: Divides period matches into a slower update event
// Assumes: match_in is a one-cycle pulse
// Notes:   Kept apart from the period path on purpose

`timescale 1ns/1ps

module tpw_postscaler
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Control
   input  wire logic       match_in,
   input  wire logic [3:0] post_sel_in,
   // Event
   output logic            event_out
);

   logic [3:0] cnt_reg;

   // Divide by post_sel_in + 1
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_reg   <= 4'h0;
         event_out <= 1'b0;
      end
      else
      begin
         event_out <= 1'b0;
         if (match_in)
         begin
            if (cnt_reg >= post_sel_in)
            begin
               cnt_reg   <= 4'h0;
               event_out <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end

endmodule // tpw_postscaler

// *** tpw_pwm_top.sv ***
// Purpose: Timer based PWM generator with Wishbone register access
// Assumes: 100 MHz ref_clk_in used as the oscillator; Wishbone classic slave
// Notes:   Registers are 8 bits wide in byte lane 0; upper bits read zero

`timescale 1ns/1ps

module tpw_pwm_top
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   // PWM pin
   output logic             pwm_out_pin_out
);

   // ------------------------------------------------------------
   // Registers and nets
   // ------------------------------------------------------------
   logic [7:0] ccp_control_reg;
   logic [7:0] period_register_reg;
   logic [7:0] duty_high_write_reg;
   logic [7:0] duty_shadow_reg;
   logic [1:0] duty_latch_reg;
   logic [7:0] timer_count_reg;
   logic [7:0] timer_ctrl_reg;
   logic       post_flag_reg;
   logic       pwm_latch_reg;

   logic       req;
   logic       wr_en;
   logic       wr_ctrl;
   logic       pwm_mode;
   logic       tick;
   logic       step_end;
   logic [1:0] fine;
   logic       period_end;
   logic       post_event;
   logic [9:0] position;
   logic [9:0] position_next;
   logic [9:0] active_duty;
   logic [9:0] pending_duty;
   logic       clear_hit;
   logic [7:0] rd_byte;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr_en    = req && wb_we_in && wb_sel_in[0];
   assign wr_ctrl  = wr_en && (wb_adr_in == tpw_pkg::TPW_OFS_CONTROL);
   assign pwm_mode = ccp_control_reg[tpw_pkg::TPW_CTL_MODE_LSB +: 4] == tpw_pkg::TPW_MODE_PWM;

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         wb_ack_out <= 1'b0;
      else
         wb_ack_out <= req;
   end

   always_comb
   begin
      if (wb_adr_in == tpw_pkg::TPW_OFS_CONTROL)
         rd_byte = ccp_control_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_PERIOD)
         rd_byte = period_register_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_DUTY_HIGH)
         rd_byte = duty_high_write_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_DUTY_SHDW)
         rd_byte = duty_shadow_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_TIMER)
         rd_byte = timer_count_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_TIMER_CTRL)
         rd_byte = timer_ctrl_reg;
      else if (wb_adr_in == tpw_pkg::TPW_OFS_STATUS)
         rd_byte = {6'h00, post_flag_reg, pwm_latch_reg};
      else
         rd_byte = 8'h00;
   end

   // Unmapped addresses still ack, reading zero
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         wb_dat_out <= 32'h0000_0000;
      else if (req && !wb_we_in)
         wb_dat_out <= {24'h00_0000, rd_byte};
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   // Writes land whenever they arrive; the duty compare uses only the shadow copy
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ccp_control_reg     <= tpw_pkg::TPW_RST_CONTROL;
         period_register_reg <= tpw_pkg::TPW_RST_PERIOD;
         duty_high_write_reg <= tpw_pkg::TPW_RST_DUTY;
         timer_ctrl_reg      <= tpw_pkg::TPW_RST_TCTRL;
      end
      else if (wr_en)
      begin
         if (wb_adr_in == tpw_pkg::TPW_OFS_CONTROL)
            ccp_control_reg <= wb_dat_in[7:0];
         else if (wb_adr_in == tpw_pkg::TPW_OFS_PERIOD)
            period_register_reg <= wb_dat_in[7:0];
         else if (wb_adr_in == tpw_pkg::TPW_OFS_DUTY_HIGH)
            duty_high_write_reg <= wb_dat_in[7:0];
         else if (wb_adr_in == tpw_pkg::TPW_OFS_TIMER_CTRL)
            timer_ctrl_reg <= {1'b0, wb_dat_in[6:0]};
      end
   end

   // ------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------
   tpw_prescaler u_prescaler
   (
      .ref_clk_in   (ref_clk_in),
      .rst_in       (rst_in),
      .run_in       (timer_ctrl_reg[tpw_pkg::TPW_TCN_ON_BIT]),
      .pre_sel_in   (timer_ctrl_reg[tpw_pkg::TPW_TCN_PRE_LSB +: 2]),
      .tick_out     (tick),
      .step_end_out (step_end),
      .fine_out     (fine)
   );

   assign period_end = tick && (timer_count_reg == period_register_reg);

   // Timer restarts on the increment after the period match
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         timer_count_reg <= 8'h00;
      else if (period_end)
         timer_count_reg <= 8'h00;
      else if (tick)
         timer_count_reg <= timer_count_reg + 8'h01;
   end

   tpw_postscaler u_postscaler
   (
      .ref_clk_in  (ref_clk_in),
      .rst_in      (rst_in),
      .match_in    (period_end),
      .post_sel_in (timer_ctrl_reg[tpw_pkg::TPW_TCN_POST_LSB +: 4]),
      .event_out   (post_event)
   );

   // Sticky update flag, write one to clear; a new event wins the clear
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         post_flag_reg <= 1'b0;
      else if (post_event)
         post_flag_reg <= 1'b1;
      else if (wr_en && wb_adr_in == tpw_pkg::TPW_OFS_STATUS && wb_dat_in[tpw_pkg::TPW_STS_POST_BIT])
         post_flag_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // Duty double buffer
   // ------------------------------------------------------------
   assign pending_duty = {duty_high_write_reg, ccp_control_reg[tpw_pkg::TPW_CTL_DUTY_LSB +: 2]};
   assign active_duty  = {duty_shadow_reg, duty_latch_reg};

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         duty_shadow_reg <= tpw_pkg::TPW_RST_DUTY;
         duty_latch_reg  <= 2'h0;
      end
      else if (period_end)
      begin
         duty_shadow_reg <= pending_duty[9:2];
         duty_latch_reg  <= pending_duty[1:0];
      end
      else if (!pwm_mode && wr_en && wb_adr_in == tpw_pkg::TPW_OFS_DUTY_SHDW)
         duty_shadow_reg <= wb_dat_in[7:0];
   end

   // ------------------------------------------------------------
   // Output latch
   // ------------------------------------------------------------
   // Compare on the last oscillator period of each fine step, so the
   // high time is exactly duty prescaled oscillator periods
   assign position      = {timer_count_reg, fine};
   assign position_next = position + 10'h001;
   assign clear_hit     = step_end && (position_next == active_duty);

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         pwm_latch_reg <= 1'b0;
      else if (wr_ctrl && wb_dat_in[7:0] == 8'h00)
         pwm_latch_reg <= 1'b0;
      else if (!pwm_mode)
         pwm_latch_reg <= 1'b0;
      else if (period_end)
         pwm_latch_reg <= (pending_duty != 10'h000);
      else if (clear_hit)
         pwm_latch_reg <= 1'b0;
   end

   // Pin is a registered copy of the PWM latch, one clock later
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         pwm_out_pin_out <= 1'b0;
      else
         pwm_out_pin_out <= pwm_latch_reg;
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_period_restart;
      @(posedge ref_clk_in) disable iff (rst_in)
      period_end |=> (timer_count_reg == 8'h00);
   endproperty
   a_period_restart: assert property (p_period_restart) else $error("Timer not cleared after period");

   property p_no_overrun;
      @(posedge ref_clk_in) disable iff (rst_in)
      (tick && timer_count_reg != period_register_reg) |=> (timer_count_reg == $past(timer_count_reg) + 8'h01);
   endproperty
   a_no_overrun: assert property (p_no_overrun) else $error("Timer did not advance on tick");

   property p_set_at_end;
      @(posedge ref_clk_in) disable iff (rst_in)
      (period_end && pwm_mode && !wr_ctrl && pending_duty != 10'h000) |=> pwm_latch_reg;
   endproperty
   a_set_at_end: assert property (p_set_at_end) else $error("Pin not set at period end");

   property p_zero_duty_low;
      @(posedge ref_clk_in) disable iff (rst_in)
      (period_end && pending_duty == 10'h000) |=> !pwm_latch_reg;
   endproperty
   a_zero_duty_low: assert property (p_zero_duty_low) else $error("Pin set with zero duty");

   property p_shadow_load;
      @(posedge ref_clk_in) disable iff (rst_in)
      period_end |=> (active_duty == $past(pending_duty));
   endproperty
   a_shadow_load: assert property (p_shadow_load) else $error("Duty not latched at period end");

   property p_shadow_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      (!period_end && pwm_mode) |=> $stable(active_duty);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("Active duty changed mid period");

   property p_zero_ctrl;
      @(posedge ref_clk_in) disable iff (rst_in)
      (wr_ctrl && wb_dat_in[7:0] == 8'h00) |=> ##1 !pwm_out_pin_out;
   endproperty
   a_zero_ctrl: assert property (p_zero_ctrl) else $error("Pin not low after control clear");

   property p_clear_on_match;
      @(posedge ref_clk_in) disable iff (rst_in)
      (clear_hit && !period_end && !wr_ctrl) |=> !pwm_latch_reg;
   endproperty
   a_clear_on_match: assert property (p_clear_on_match) else $error("Pin not cleared on duty match");

   property p_pin_follows;
      @(posedge ref_clk_in) disable iff (rst_in)
      ##1 (pwm_out_pin_out == $past(pwm_latch_reg));
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("Pin does not follow latch");

   property p_ack_pulse;
      @(posedge ref_clk_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held for two cycles");

   property p_shadow_ro;
      @(posedge ref_clk_in) disable iff (rst_in)
      (pwm_mode && wr_en && wb_adr_in == tpw_pkg::TPW_OFS_DUTY_SHDW && !period_end) |=> $stable(duty_shadow_reg);
   endproperty
   a_shadow_ro: assert property (p_shadow_ro) else $error("Shadow written in PWM mode");

   property p_mode_off_low;
      @(posedge ref_clk_in) disable iff (rst_in)
      !pwm_mode |=> !pwm_latch_reg;
   endproperty
   a_mode_off_low: assert property (p_mode_off_low) else $error("Latch high outside PWM mode");

   property p_tick_gap;
      @(posedge ref_clk_in) disable iff (rst_in)
      tick |=> (!tick) [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Timer ticks closer than four clocks");

   property p_rise_at_end;
      @(posedge ref_clk_in) disable iff (rst_in)
      $rose(pwm_latch_reg) |-> $past(period_end);
   endproperty
   a_rise_at_end: assert property (p_rise_at_end) else $error("Latch rose away from period end");

   property p_fall_cause;
      @(posedge ref_clk_in) disable iff (rst_in)
      $fell(pwm_latch_reg) |-> ($past(clear_hit) || $past(period_end) || !$past(pwm_mode) || $past(wr_ctrl));
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("Latch fell without a cause");

   property p_post_after_match;
      @(posedge ref_clk_in) disable iff (rst_in)
      post_event |-> $past(period_end);
   endproperty
   a_post_after_match: assert property (p_post_after_match) else $error("Update event without match");

   property p_timer_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      !tick |=> $stable(timer_count_reg);
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("Timer moved without tick");

   property p_shadow_from_high;
      @(posedge ref_clk_in) disable iff (rst_in)
      period_end |=> (duty_shadow_reg == $past(duty_high_write_reg));
   endproperty
   a_shadow_from_high: assert property (p_shadow_from_high) else $error("Shadow not taken from high byte");

   property p_idle_no_tick;
      @(posedge ref_clk_in) disable iff (rst_in)
      !timer_ctrl_reg[tpw_pkg::TPW_TCN_ON_BIT] |-> (!tick && !step_end);
   endproperty
   a_idle_no_tick: assert property (p_idle_no_tick) else $error("Time base runs while off");

   // Timer above a lowered period may wrap, so only in-range counts are judged
   property p_no_clear_over;
      @(posedge ref_clk_in) disable iff (rst_in)
      (pwm_mode && timer_count_reg <= period_register_reg
       && {1'b0, active_duty} > ({1'b0, period_register_reg, 2'h3} + 11'h001)) |-> !clear_hit;
   endproperty
   a_no_clear_over: assert property (p_no_clear_over) else $error("Clear match beyond period");

endmodule // tpw_pwm_top

// *** tpw_load_model.sv ***
// Purpose: Load on the PWM pin that times each pulse in clocks
// Assumes: Pin is a plain push-pull output, sampled on ref_clk_in
// Notes:   First period after reset is counted from reset release

`timescale 1ns/1ps

module tpw_load_model
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Driven pin, sampled on every rising ref_clk_in edge
   input  wire logic        pin_in,
   // Measurements in clocks
   output logic [15:0]      high_len_out,
   output logic [15:0]      period_len_out,
   output logic [15:0]      rise_cnt_out
);
   logic        pin_prev_reg;
   logic [15:0] span_reg;

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_prev_reg   <= 1'b0;
         span_reg       <= 16'h0000;
         high_len_out   <= 16'h0000;
         period_len_out <= 16'h0000;
         rise_cnt_out   <= 16'h0000;
      end
      else
      begin
         pin_prev_reg <= pin_in;
         span_reg     <= span_reg + 16'h0001;
         if (pin_in && !pin_prev_reg)
         begin
            period_len_out <= span_reg;
            span_reg       <= 16'h0001;
            rise_cnt_out   <= rise_cnt_out + 16'h0001;
         end
         if (!pin_in && pin_prev_reg)
            high_len_out <= span_reg;
      end
   end
endmodule // tpw_load_model

// *** tb.sv ***
// Purpose: Self-checking bench for the timer based PWM block
// Assumes: Wishbone classic single cycles, ack one cycle after request
// Notes:   Each scenario starts from a fresh reset

`timescale 1ns/1ps

module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        ack;
   logic        pin;
   logic [15:0] high_len;
   logic [15:0] period_len;
   logic [15:0] rise_cnt;
   int          mismatches = 0;
   int          cmp_count = 0;

   always #5 clk = ~clk;

   tpw_pwm_top uut
   (
      .ref_clk_in      (clk),
      .rst_in          (rst),
      .wb_cyc_in       (cyc),
      .wb_stb_in       (stb),
      .wb_we_in        (we),
      .wb_adr_in       (adr),
      .wb_sel_in       (sel),
      .wb_dat_in       (wdat),
      .wb_dat_out      (rdat),
      .wb_ack_out      (ack),
      .pwm_out_pin_out (pin)
   );

   tpw_load_model load
   (
      .ref_clk_in     (clk),
      .rst_in         (rst),
      .pin_in         (pin),
      .high_len_out   (high_len),
      .period_len_out (period_len),
      .rise_cnt_out   (rise_cnt)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
   begin
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task automatic tally_and_finish;
   begin
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
   begin
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'h1;
      wdat <= {24'h000000, d};
      @(posedge clk);
      // Ack is read before this edge's updates land
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         mismatches++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
   begin
      wb_cycle(1'b1, a, d, q);
   end
   endtask

   task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
   begin
      wb_cycle(1'b0, a, 8'h00, q);
      check(what, q, {24'h000000, exp});
   end
   endtask

   task automatic do_reset;
   begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
   end
   endtask

   task automatic wait_rise;
      int n;
      logic [15:0] start;
   begin
      n = 0;
      start = rise_cnt;
      while (rise_cnt === start && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000)
         mismatches++;
   end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values;
      logic [7:0] ofs [8];
      logic [7:0] exp [8];
   begin
      ofs = '{tpw_pkg::TPW_OFS_CONTROL, tpw_pkg::TPW_OFS_PERIOD, tpw_pkg::TPW_OFS_DUTY_HIGH,
              tpw_pkg::TPW_OFS_DUTY_SHDW, tpw_pkg::TPW_OFS_TIMER, tpw_pkg::TPW_OFS_TIMER_CTRL,
              tpw_pkg::TPW_OFS_STATUS, 8'h1c};
      exp = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++)
         rd_check("reset value", ofs[i], exp[i]);
      check("pin after reset", pin, 1'b0);
   end
   endtask

   task automatic t_prescale;
      int f [4];
   begin
      f = '{1, 4, 16, 16};
      for (int i = 0; i < 4; i++)
      begin
         do_reset();
         // Duty 9 from high byte 2 and low bits 01
         wr(tpw_pkg::TPW_OFS_CONTROL, 8'h1c);
         wr(tpw_pkg::TPW_OFS_PERIOD, 8'h03);
         wr(tpw_pkg::TPW_OFS_DUTY_HIGH, 8'h02);
         // Last entry uses prescale code 3 with a slow postscaler
         wr(tpw_pkg::TPW_OFS_TIMER_CTRL, (i == 3) ? 8'h7f : {6'h01, 2'(i)});
         repeat (3) wait_rise();
         repeat (16 * f[i]) @(posedge clk);
         check("period clocks", period_len, 32'(16 * f[i]));
         check("high clocks", high_len, 32'(9 * f[i]));
         rd_check("shadow loaded", tpw_pkg::TPW_OFS_DUTY_SHDW, 8'h02);
      end
   end
   endtask

   task automatic t_duty_zero;
   begin
      do_reset();
      wr(tpw_pkg::TPW_OFS_CONTROL, 8'h0c);
      wr(tpw_pkg::TPW_OFS_PERIOD, 8'h03);
      // Postscale divide by two; about six matches in the wait
      wr(tpw_pkg::TPW_OFS_TIMER_CTRL, 8'h0c);
      repeat (100) @(posedge clk);
      check("rises at zero duty", rise_cnt, 32'h0);
      // Timer off first so no new event races the clear
      wr(tpw_pkg::TPW_OFS_TIMER_CTRL, 8'h08);
      rd_check("update flag set", tpw_pkg::TPW_OFS_STATUS, 8'h02);
      wr(tpw_pkg::TPW_OFS_STATUS, 8'h02);
      rd_check("update flag cleared", tpw_pkg::TPW_OFS_STATUS, 8'h00);
   end
   endtask

   task automatic t_duty_over_and_clear;
      int lows;
   begin
      do_reset();
      lows = 0;
      wr(tpw_pkg::TPW_OFS_CONTROL, 8'h0c);
      wr(tpw_pkg::TPW_OFS_PERIOD, 8'h03);
      wr(tpw_pkg::TPW_OFS_DUTY_HIGH, 8'h10);
      wr(tpw_pkg::TPW_OFS_TIMER_CTRL, 8'h04);
      wait_rise();
      repeat (64)
      begin
         @(posedge clk);
         if (pin !== 1'b1)
            lows++;
      end
      check("low clocks at long duty", lows, 32'h0);
      rd_check("status while high", tpw_pkg::TPW_OFS_STATUS, 8'h03);
      wr(tpw_pkg::TPW_OFS_CONTROL, 8'h00);
      repeat (40) @(posedge clk);
      check("pin after control clear", pin, 1'b0);
      rd_check("duty kept", tpw_pkg::TPW_OFS_DUTY_HIGH, 8'h10);
   end
   endtask

   task automatic t_double_buffer;
   begin
      do_reset();
      wr(tpw_pkg::TPW_OFS_CONTROL, 8'h0c);
      wr(tpw_pkg::TPW_OFS_PERIOD, 8'h3f);
      wr(tpw_pkg::TPW_OFS_DUTY_HIGH, 8'h05);
      wr(tpw_pkg::TPW_OFS_TIMER_CTRL, 8'h04);
      repeat (2) wait_rise();
      // Early in a 256-clock period, far from the next load
      wr(tpw_pkg::TPW_OFS_DUTY_HIGH, 8'h20);
      wr(tpw_pkg::TPW_OFS_DUTY_SHDW, 8'haa);
      rd_check("shadow before period end", tpw_pkg::TPW_OFS_DUTY_SHDW, 8'h05);
      wait_rise();
      check("old high time", high_len, 32'd20);
      repeat (160) @(posedge clk);
      rd_check("shadow after period end", tpw_pkg::TPW_OFS_DUTY_SHDW, 8'h20);
      check("new high time", high_len, 32'd128);
   end
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_prescale();
      t_duty_zero();
      t_duty_over_and_clear();
      t_double_buffer();
      tally_and_finish();
   end

   initial
   begin
      // Roughly six times the expected run
      repeat (25000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
endmodule // tb
